/* common/sfx_pkg.sv */
/*
  shared constants of the serial character formatting block.
  assumes a 250 MHz pclk and a 32-bit APB master.
*/
package sfx_pkg;
  localparam int CLK_NS = 4;
  localparam int TENTH_NS = 100_000_000;
  localparam int TENTH_CYC = TENTH_NS / CLK_NS;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DELAY = 8'h04;
  localparam logic [7:0] A_TXDATA = 8'h08;
  localparam logic [7:0] A_OTAB = 8'h0C;
  localparam logic [7:0] A_ITAB = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  // control fields
  localparam int F_WID = 0;
  localparam int F_TERM = 2;
  localparam int F_TSEL = 3;
  localparam int F_PAR = 4;
  localparam int F_STOP2 = 6;
  localparam int F_REC = 7;
  localparam int F_NL = 8;
  localparam int F_EOB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0046;
  localparam logic [1:0] W5 = 2'h0;
  localparam logic [1:0] W6 = 2'h1;
  localparam logic [1:0] W7 = 2'h2;
  localparam logic [1:0] W8 = 2'h3;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] STOP_1 = 2'h0;
  localparam logic [1:0] STOP_15 = 2'h1;
  localparam logic [1:0] STOP_2 = 2'h2;
  localparam logic [7:0] C_EOR = 8'hE3;
  localparam logic [7:0] C_EOB = 8'hFF;
  localparam logic [15:0] DLY_MIN = 16'h0001;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 32;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_NL   = 3'b010,
    S_EOB  = 3'b100
  } fmt_st_t;
endpackage

/* rtl/sfx_top.sv */
/*
  character fifo and output/input formatting with translation tables.
  assumes the shifter takes tx_code on tx_valid&tx_ready and rx_code
  arrives as one-cycle rx_valid pulses from the receive path.
*/
// Function
// - with terminators on, end-of-record sends new-line then end-of-block
// - record variant also sends terminators at physical end of buffer
// - terminators off suppresses them at end-of-record; default on
// - host characters mapping to terminators are always sent
// - delay command halts command processing for n tenths of a second
// - delay count 1..65535, may be issued repeatedly
// - 6-bit received codes go through the selected table
// - table select picks one of two 6-bit tables both ways, first default
// - in 5- to 7-bit modes host characters pass the output table before transmit
// - any output table entry may be rewritten
// - in 5- to 7-bit modes received codes pass the input table before storing
// - any input table entry may be rewritten
// - 7-bit parity even or odd, generated and checked
// - parity none skips checks and sends a zero parity bit
// - one, one and a half or two stop bits after each character
// - stop count selectable only for 7- and 8-bit codes
// - stop length 1.5 for 5-bit, 1 for 6-bit, default 2 otherwise
`timescale 1ns/1ns
module sfx_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       rd;
    logic [AW-1:0]       wr;
    logic [AW:0]         cnt;
  } fifo_t;
  fifo_t s, next_s;
  logic push, pop;
  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr = s.wr + 1'b1;
    end
    if (pop) next_s.rd = s.rd + 1'b1;
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s <= '0;
    else s <= next_s;
  end
  assign in_ready = s.cnt != (AW+1)'(D);
  assign out_valid = s.cnt != '0;
  assign out_data = s.mem[s.rd];
endmodule

module sfx_top
  import sfx_pkg::*;
#(
  parameter int TENTH = TENTH_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [7:0]       tx_code,
  output logic [1:0]       tx_stop,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_code,
  output logic             rx_char_valid,
  output logic [7:0]       rx_char,
  output logic             rx_parity_err,
  output logic             delay_busy
);
  typedef struct packed {
    logic [511:0][6:0] otab;
    logic [255:0][7:0] itab;
    logic [31:0]       ctrl;
    fmt_st_t           st;
    logic [15:0]       dly;
    logic [31:0]       sub;
    logic              busy;
    logic              rdy;
    logic              err;
    logic [31:0]       rdat;
    logic              txv;
    logic [7:0]        txc;
    logic [1:0]        txs;
    logic              rxv;
    logic [7:0]        rxc;
    logic              rxe;
  } top_t;
  top_t s, next_s;

  // standard mappings: codes follow the host character's low bits
  function automatic top_t reset_state();
    top_t r;
    r = '0;
    for (int i = 0; i < 512; i++) r.otab[i] = 7'(i);
    for (int i = 0; i < 256; i++) r.itab[i] = 8'(i);
    r.ctrl = CTRL_RST;
    r.st = S_IDLE;
    return r;
  endfunction

  function automatic logic [6:0] wmask(input logic [1:0] w);
    case (w)
      W5: wmask = 7'h1F;
      W6: wmask = 7'h3F;
      default: wmask = 7'h7F;
    endcase
  endfunction

  // translate a host character to the line code, parity in bit 7
  function automatic logic [7:0] to_line(input top_t t, input logic [7:0] ch);
    logic [1:0] w;
    logic [6:0] c;
    w = t.ctrl[F_WID+:2];
    c = t.otab[{w == W6 && t.ctrl[F_TSEL], ch}] & wmask(w);
    if (w == W8) to_line = ch;
    else if (w != W7 || t.ctrl[F_PAR+:2] == PAR_NONE) to_line = {1'b0, c};
    else if (t.ctrl[F_PAR+:2] == PAR_ODD) to_line = {~^c, c};
    else to_line = {^c, c};
  endfunction

  logic [1:0] wid, par;
  logic fi_v, fi_r, fo_v, fo_r;
  logic [7:0] fo_d;
  logic acc, done, hit, stall;
  logic [7:0] rx_idx;

  sfx_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (fi_v),
    .in_ready  (fi_r),
    .in_data   (pwdata[7:0]),
    .out_valid (fo_v),
    .out_ready (fo_r),
    .out_data  (fo_d)
  );

  always_comb begin
    next_s = s;
    wid = s.ctrl[F_WID+:2];
    par = s.ctrl[F_PAR+:2];
    acc = psel && penable;
    done = acc && s.rdy;
    hit = paddr == A_CTRL || paddr == A_DELAY || paddr == A_TXDATA ||
          paddr == A_OTAB || paddr == A_ITAB || paddr == A_STAT;
    stall = s.busy || (pwrite && paddr == A_TXDATA && !fi_r);
    fi_v = done && pwrite && paddr == A_TXDATA && !s.err;
    fo_r = s.st == S_IDLE && !s.txv;
    // apb answer one cycle after the access phase starts, or one cycle after a delay or full-fifo stall ends
    next_s.rdy = acc && !s.rdy && !stall;
    next_s.err = 1'b0;
    if (acc && !s.rdy && !stall) begin
      next_s.err = !hit || (pwrite && paddr == A_DELAY && pwdata[15:0] < DLY_MIN);
      case (paddr)
        A_CTRL: next_s.rdat = s.ctrl;
        A_DELAY: next_s.rdat = {16'h0000, s.dly};
        A_STAT: next_s.rdat = {28'h000_0000, s.txv, fo_v, !fi_r, s.busy};
        default: next_s.rdat = 32'h0000_0000;
      endcase
    end
    if (done && pwrite && !s.err) begin
      case (paddr)
        A_CTRL: begin
          next_s.ctrl = pwdata;
          if (pwdata[F_WID+:2] != W7) next_s.ctrl[F_PAR+:2] = PAR_NONE;
          if (pwdata[F_WID+:2] == W5 || pwdata[F_WID+:2] == W6) begin
            next_s.ctrl[F_STOP2] = 1'b0;
          end
        end
        A_DELAY: begin
          next_s.dly = pwdata[15:0];
          next_s.sub = 32'(TENTH - 1);
          next_s.busy = 1'b1;
        end
        A_OTAB: next_s.otab[{pwdata[16], pwdata[15:8]}] = pwdata[6:0];
        A_ITAB: next_s.itab[{pwdata[16], pwdata[14:8]}] = pwdata[7:0];
        default: ;
      endcase
    end
    // tenth-second pacing of the delay
    if (s.busy && !(done && pwrite)) begin
      if (s.sub == 32'h0000_0000) begin
        next_s.sub = 32'(TENTH - 1);
        next_s.dly = s.dly - 16'h0001;
        if (s.dly == DLY_MIN) next_s.busy = 1'b0;
      end else begin
        next_s.sub = s.sub - 32'h0000_0001;
      end
    end
    // stop bits per code width
    case (wid)
      W5: next_s.txs = STOP_15;
      W6: next_s.txs = STOP_1;
      default: next_s.txs = s.ctrl[F_STOP2] ? STOP_2 : STOP_1;
    endcase
    if (s.txv && tx_ready) next_s.txv = 1'b0;
    unique case (s.st)
      S_IDLE: begin
        if (fo_v && fo_r) begin
          if (fo_d == C_EOR) begin
            if (s.ctrl[F_TERM]) next_s.st = S_NL;
          end else if (fo_d == C_EOB) begin
            if (s.ctrl[F_TERM] && s.ctrl[F_REC]) next_s.st = S_NL;
          end else begin
            next_s.txv = 1'b1;
            next_s.txc = to_line(s, fo_d);
          end
        end
      end
      S_NL: begin
        if (!s.txv) begin
          next_s.txv = 1'b1;
          next_s.txc = to_line(s, s.ctrl[F_NL+:8]);
          next_s.st = S_EOB;
        end
      end
      S_EOB: begin
        if (!s.txv) begin
          next_s.txv = 1'b1;
          next_s.txc = to_line(s, s.ctrl[F_EOB+:8]);
          next_s.st = S_IDLE;
        end
      end
    endcase
    // receive translation and parity check
    rx_idx = {wid == W6 && s.ctrl[F_TSEL], rx_code[6:0] & wmask(wid)};
    next_s.rxv = rx_valid;
    if (rx_valid) begin
      next_s.rxc = wid == W8 ? rx_code : s.itab[rx_idx];
      next_s.rxe = wid == W7 && par != PAR_NONE &&
                   ((^rx_code) != (par == PAR_ODD));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s <= reset_state();
    else s <= next_s;
  end

  assign prdata = s.rdat;
  assign pready = s.rdy;
  assign pslverr = s.err;
  assign tx_valid = s.txv;
  assign tx_code = s.txc;
  assign tx_stop = s.txs;
  assign rx_char_valid = s.rxv;
  assign rx_char = s.rxc;
  assign rx_parity_err = s.rxe;
  assign delay_busy = s.busy;

  property p_eor_nl;
    @(posedge pclk) disable iff (!presetn)
    s.st == S_IDLE && fo_v && fo_r && fo_d == C_EOR && s.ctrl[F_TERM]
      |=> s.st == S_NL;
  endproperty
  a_eor_nl: assert property (p_eor_nl) else $error("no new-line after eor");
  property p_rec_eob;
    @(posedge pclk) disable iff (!presetn)
    s.st == S_IDLE && fo_v && fo_r && fo_d == C_EOB
      |=> s.st == (s.ctrl[F_TERM] && s.ctrl[F_REC] ? S_NL : S_IDLE);
  endproperty
  a_rec_eob: assert property (p_rec_eob) else $error("bad end-of-buffer");
  property p_term_off;
    @(posedge pclk) disable iff (!presetn)
    s.st == S_IDLE && fo_v && fo_r && fo_d == C_EOR && !s.ctrl[F_TERM]
      |=> s.st == S_IDLE && !s.txv;
  endproperty
  a_term_off: assert property (p_term_off) else $error("terminator sent");
  property p_delay;
    @(posedge pclk) disable iff (!presetn)
    s.busy && acc && !s.rdy |=> !s.rdy;
  endproperty
  a_delay: assert property (p_delay) else $error("answer during delay");
  property p_dly_zero;
    @(posedge pclk) disable iff (!presetn)
    acc && !s.rdy && !stall && pwrite && paddr == A_DELAY && pwdata[15:0] == 16'h0000
      |=> s.err ##1 !s.busy || $past(s.busy, 2);
  endproperty
  a_dly_zero: assert property (p_dly_zero) else $error("zero delay taken");
  property p_par_none;
    @(posedge pclk) disable iff (!presetn)
    $rose(tx_valid) && $past(par) == PAR_NONE && $past(wid) != W8 |-> !tx_code[7];
  endproperty
  a_par_none: assert property (p_par_none) else $error("parity bit set");
  property p_par;
    @(posedge pclk) disable iff (!presetn)
    rx_valid && wid == W7 && par == PAR_EVEN |=> rx_parity_err == ^$past(rx_code);
  endproperty
  a_par: assert property (p_par) else $error("even parity check wrong");
  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    ##1 $stable(wid) && $past(wid) == W5 |-> tx_stop == STOP_15;
  endproperty
  a_stop: assert property (p_stop) else $error("5-bit stop not 1.5");
  property p_rx8;
    @(posedge pclk) disable iff (!presetn)
    rx_valid && wid == W8 |=> rx_char_valid && rx_char == $past(rx_code);
  endproperty
  a_rx8: assert property (p_rx8) else $error("8-bit receive altered");
  property p_rx_lat;
    @(posedge pclk) disable iff (!presetn)
    rx_valid |=> rx_char_valid;
  endproperty
  a_rx_lat: assert property (p_rx_lat) else $error("receive char not presented");
  property p_tx_hold;
    @(posedge pclk) disable iff (!presetn)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_code);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("line code dropped");
  property p_nl_eob;
    @(posedge pclk) disable iff (!presetn)
    s.st == S_NL && !s.txv |=> s.st == S_EOB && tx_valid;
  endproperty
  a_nl_eob: assert property (p_nl_eob) else $error("end-of-block not next");
  property p_stop6;
    @(posedge pclk) disable iff (!presetn)
    ##1 $stable(wid) && $past(wid) == W6 |-> tx_stop == STOP_1;
  endproperty
  a_stop6: assert property (p_stop6) else $error("6-bit stop not 1");
  property p_par_w7;
    @(posedge pclk) disable iff (!presetn)
    wid != W7 |-> par == PAR_NONE;
  endproperty
  a_par_w7: assert property (p_par_w7) else $error("parity outside 7-bit");
  c_term: cover property (@(posedge pclk) s.st == S_NL ##[1:20] s.st == S_EOB);
  c_rec_eob: cover property (@(posedge pclk) s.st == S_NL && s.ctrl[F_REC]);
  c_par_err: cover property (@(posedge pclk) rx_parity_err);
  c_delay: cover property (@(posedge pclk) $fell(s.busy));
  c_full: cover property (@(posedge pclk) !fi_r);
endmodule

/* dv/sfx_line_model.sv */
/*
  serial line model: takes transmitted codes, sends received codes.
  assumes pclk and presetn of the block under test.
*/
`timescale 1ns/1ns
module sfx_line_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       slow,
  input  wire logic       hold,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic [7:0] tx_code,
  output logic            rx_valid,
  output logic [7:0]      rx_code
);
  logic [7:0] got[$];
  logic [1:0] cnt;
  initial begin
    rx_valid = 1'b0;
    rx_code = 8'h00;
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      tx_ready <= !hold && (!slow || cnt == 2'h3);
      if (tx_valid && tx_ready) begin
        got.push_back(tx_code);
      end
    end
  end
  // parity bit is sent as the bench gives it
  task automatic send_rx(input logic [7:0] c);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_code <= c;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_code <= ~c;
  endtask
endmodule

/* dv/serial_char_format_translate_bench.sv */
/*
  bench of the formatting block: apb tasks and one task per scenario.
  assumes the line model of dv/sfx_line_model.sv.
*/
`timescale 1ns/1ns
module serial_char_format_translate_bench;
  import sfx_pkg::*;
  localparam int T = 10;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        tx_valid, tx_ready, rx_valid, rx_char_valid, rx_parity_err;
  logic        delay_busy, slow, hold, e;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  paddr, tx_code, rx_code, rx_char;
  logic [1:0]  tx_stop;
  int          n_fail, total_checks;
  sfx_top #(.TENTH(T)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_code(tx_code), .tx_stop(tx_stop), .rx_valid(rx_valid),
    .rx_code(rx_code), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_parity_err(rx_parity_err), .delay_busy(delay_busy));
  sfx_line_model line (.pclk(pclk), .presetn(presetn), .slow(slow), .hold(hold),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_code(tx_code),
    .rx_valid(rx_valid), .rx_code(rx_code));
  always #2 pclk = ~pclk;
  task automatic close_out();
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  function automatic logic [31:0] cfg(input logic [7:0] lo);
    return {16'h000A, 8'h0D, lo};
  endfunction
  task automatic see_tx(input logic [7:0] x);
    int n;
    n = 0;
    while (line.got.size() == 0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk({24'h0, line.got.size() > 0 ? line.got.pop_front() : ~x}, {24'h0, x});
  endtask
  task automatic rx_see(input logic [7:0] c, input logic [7:0] x);
    line.send_rx(c);
    #1;
    chk({31'h0, rx_char_valid}, 32'h1);
    chk({24'h0, rx_char}, {24'h0, x});
  endtask
  task automatic t_parity();
    logic [7:0] lo[3] = '{8'h06, 8'h16, 8'h26};
    logic [7:0] x[3] = '{8'h43, 8'hC3, 8'h43};
    for (int i = 0; i < 3; i++) begin
      wr(A_CTRL, cfg(lo[i]));
      wr(A_TXDATA, 32'h43);
      see_tx(x[i]);
    end
  endtask
  task automatic t_term();
    slow <= 1'b1;
    wr(A_CTRL, cfg(8'h06));
    wr(A_TXDATA, 32'hE3);
    wr(A_TXDATA, 32'hFF);
    see_tx(8'h0D);
    see_tx(8'h0A);
    wr(A_CTRL, cfg(8'h02));
    wr(A_TXDATA, 32'hE3);
    wr(A_TXDATA, 32'h0D);
    see_tx(8'h0D);
    repeat (40) @(posedge pclk);
    chk(32'(line.got.size()), 32'h0);
    wr(A_CTRL, cfg(8'h86));
    wr(A_TXDATA, 32'hFF);
    see_tx(8'h0D);
    see_tx(8'h0A);
    slow <= 1'b0;
  endtask
  task automatic t_tables();
    wr(A_CTRL, cfg(8'h06));
    wr(A_OTAB, 32'h0000_507A);
    wr(A_TXDATA, 32'h50);
    wr(A_TXDATA, 32'h5A);
    see_tx(8'h7A);
    see_tx(8'h5A);
    wr(A_ITAB, 32'h0000_705A);
    rx_see(8'h70, 8'h5A);
    chk({31'h0, rx_parity_err}, 32'h0);
    rx_see(8'h7A, 8'h7A);
    wr(A_CTRL, cfg(8'h0D));
    wr(A_ITAB, 32'h0001_0258);
    wr(A_OTAB, 32'h0001_4125);
    rx_see(8'h02, 8'h58);
    wr(A_TXDATA, 32'h41);
    see_tx(8'h25);
    wr(A_CTRL, cfg(8'h05));
    rx_see(8'h02, 8'h02);
    wr(A_TXDATA, 32'h41);
    see_tx(8'h01);
    wr(A_CTRL, cfg(8'h16));
    rx_see(8'h43, 8'h43);
    chk({31'h0, rx_parity_err}, 32'h1);
    rx_see(8'hC3, 8'h43);
    chk({31'h0, rx_parity_err}, 32'h0);
    wr(A_CTRL, cfg(8'h26));
    rx_see(8'h43, 8'h43);
    chk({31'h0, rx_parity_err}, 32'h0);
  endtask
  task automatic t_stop();
    logic [7:0] lo[4] = '{8'h40, 8'h41, 8'h02, 8'h43};
    logic [1:0] st[4] = '{STOP_15, STOP_1, STOP_1, STOP_2};
    for (int i = 0; i < 4; i++) begin
      wr(A_CTRL, cfg(lo[i]));
      repeat (2) @(posedge pclk);
      chk({30'h0, tx_stop}, {30'h0, st[i]});
    end
  endtask
  task automatic t_delay();
    time t0;
    int  dt;
    wr(A_DELAY, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, e}, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wr(A_DELAY, 32'h3);
      t0 = $time;
      @(posedge pclk);
      chk({31'h0, delay_busy}, 32'h1);
      apb(1'b0, A_CTRL, 32'h0);
      dt = int'(($time - t0) / CLK_NS);
      chk({31'h0, dt >= 3 * T - 2 && dt <= 3 * T + 8}, 32'h1);
    end
  endtask
  task automatic t_fifo();
    hold <= 1'b1;
    wr(A_CTRL, cfg(8'h07));
    rx_see(8'hE5, 8'hE5);
    for (int i = 0; i < 33; i++) wr(A_TXDATA, 32'h20 + i);
    apb(1'b0, A_STAT, 32'h0);
    chk({31'h0, r[1]}, 32'h1);
    hold <= 1'b0;
    for (int i = 0; i < 33; i++) see_tx(8'h20 + 8'(i));
    apb(1'b0, A_STAT, 32'h0);
    chk({31'h0, r[2]}, 32'h0);
  endtask
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, slow, hold} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    n_fail = 0;
    total_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CTRL, 32'h0);
    chk(r, CTRL_RST);
    chk({30'h0, tx_stop}, {30'h0, STOP_2});
    t_parity();
    t_term();
    t_tables();
    t_stop();
    t_delay();
    t_fifo();
    close_out();
  end
  initial begin
    #400_000;
    n_fail++;
    close_out();
  end
endmodule
